/* File: hw/fse_consts.svh */
`ifndef FSE_CONSTS_SVH
`define FSE_CONSTS_SVH
// receive timer compare: 8 data bits, functional clock / 4
`define FSE_UART_CMP_DFLT 16'h0f01
// spi clock timer compare: 32 bits, functional clock / 8 after the divider clamp
`define FSE_SPI_CMP_DFLT 16'h3f01
// select timer compare that never matches
`define FSE_NEVER_CMP 16'hffff
// fastest spi shift clock as a divider of the functional clock
`define FSE_SPI_MIN_DIV 8
// least half-period reload that keeps the spi divider legal
`define FSE_SPI_MIN_HALF 8'((`FSE_SPI_MIN_DIV / 2) - 1)
// input setup in functional clock cycles through the pin synchroniser
`define FSE_SPI_SETUP_CYC 3
// receive shifter start/stop settings
`define FSE_START_CHECK 2'b10
`define FSE_STOP_CHECK 2'b11
// reset values
`define FSE_WORD_RST 32'h0000_0000
`define FSE_BYTE_RST 8'h00
`endif

/* File: hw/fse_pkg.sv */
package fse_pkg;
  // timer state, gray coded along idle -> run -> stop
  typedef enum logic [1:0] {
    FSE_IDLE = 2'b00,
    FSE_RUN = 2'b01,
    FSE_STOP = 2'b11
  } fse_state_t;

  // static configuration carried as one word
  typedef struct packed {
    logic spi_mode;
    logic rts_en;
    logic cpha;
    logic msb_first;
    logic shifter_pin_invert;
    logic timer_pin_invert;
    logic [1:0] shifter_stop_bit_cfg;
    logic [1:0] shifter_start_bit_cfg;
    logic [15:0] timer_compare_value;
  } fse_cfg_t;

  // whole state of the engine
  typedef struct packed {
    fse_state_t st;
    logic [2:0] rx_sync;
    logic [2:0] mi_sync;
    logic rx_lvl;
    logic mi_lvl;
    logic tclk;
    logic first;
    logic [7:0] lo;
    logic [7:0] cnt;
    logic [31:0] rx_sh;
    logic [31:0] tx_sh;
    logic [31:0] tx_buf;
    logic tx_empty;
    logic [31:0] rx_buf;
    logic rx_flag;
    logic err_flag;
    logic tmr_flag;
    logic rts;
    logic mosi;
    logic sck;
    logic ss_n;
  } fse_regs_t;
endpackage

/* File: hw/fse_engine.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fse_consts.svh"
// Overview of operation
// - receive samples pin 0 on clock fall
// - compare upper byte edges, lower byte half-divider
// - receive timer starts on start edge
// - dual 8-bit counter on inverted pin 0
// - byte-swapped view, bit-swapped for msb first
// - request-to-send asserted blocks start detection
// - request-to-send sets on start, clears on read
// - pin edges resynchronise the receive timer when request-to-send is enabled
// - receive timer start gated by the request-to-send flag
// - request-to-send timer never compares
// - request-to-send driven on pin 1
// - spi clock no faster than divide by 8
// - phase 0: drive on fall, sample rise
// - spi compare sets bits and divider
// - spi clock idles low unless timer pin inverted, starts on trigger
// - shift clock on pin 2, tx-flag triggered
// - select timer follows clock timer, active low
// - phase 1 holds select while buffer full
// - phase 1 loads on first shift, samples fall
// - status, error and timer flags raise events
module fse_engine
  import fse_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire fse_cfg_t I_CFG,
  input wire logic I_RXD,
  input wire logic I_MISO,
  input wire logic [31:0] I_TX_DATA,
  input wire logic I_TX_WRITE,
  input wire logic I_RX_READ,
  input wire logic I_ERR_CLEAR,
  input wire logic I_TMR_CLEAR,
  output logic [31:0] O_RX_DATA,
  output logic O_RX_READY,
  output logic O_RX_ERROR,
  output logic O_TIMER_DONE,
  output logic O_TX_EMPTY,
  output logic O_RTS,
  output logic O_MOSI,
  output logic O_SCK,
  output logic O_SS_N
);

  // swap bytes of a word
  function automatic logic [31:0] byte_swap(input logic [31:0] w);
    byte_swap = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  // reverse all bits of a word
  function automatic logic [31:0] bit_swap(input logic [31:0] w);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 32; i++)
    begin
      r[i] = w[31 - i];
    end
    bit_swap = r;
  endfunction

  fse_regs_t q_r; // registered state
  fse_regs_t q_nxt; // next state
  logic [7:0] half; // half-period reload of the low counter
  logic expire; // low counter reached zero this cycle
  logic rx_bit; // receive data after optional inversion
  logic rx_edge; // filtered receive level changed
  logic start_seen; // idle line went low, start bit begins
  logic [31:0] rx_word; // received word with next sample shifted in
  logic mi_now; // filtered miso as soon as stages two and three agree

  // derived terms shared by the next-state logic
  always_comb
  begin
    // lower byte is half the divider minus one
    half = I_CFG.timer_compare_value[7:0];
    // clamp the spi divider to at least 8
    if (I_CFG.spi_mode && (half < `FSE_SPI_MIN_HALF))
    begin
      half = `FSE_SPI_MIN_HALF;
    end
    expire = (q_r.lo == `FSE_BYTE_RST);
    // optional inversion of the receive pin
    rx_bit = q_r.rx_lvl ^ I_CFG.shifter_pin_invert;
    rx_edge = (q_r.rx_sync[2] == q_r.rx_sync[1]) && (q_r.rx_sync[2] != q_r.rx_lvl);
    // inverted pin rising edge is a start falling edge
    start_seen = rx_edge && q_r.rx_lvl && !q_r.rx_sync[2];
    // take miso in the cycle that stages two and three agree
    // waiting for the held level costs a fourth cycle and misses a 4-cycle half period
    mi_now = (q_r.mi_sync[2] == q_r.mi_sync[1]) ? q_r.mi_sync[2] : q_r.mi_lvl;
    rx_word = {(I_CFG.spi_mode ? mi_now : rx_bit), q_r.rx_sh[31:1]};
  end

  // next-state logic for timers, shifters and flags
  always_comb
  begin
    q_nxt = q_r;
    // three-stage synchronisers; first stage feeds only the second
    q_nxt.rx_sync = {q_r.rx_sync[1:0], I_RXD};
    q_nxt.mi_sync = {q_r.mi_sync[1:0], I_MISO};
    // a level counts once stages two and three agree
    if (q_r.rx_sync[2] == q_r.rx_sync[1])
    begin
      q_nxt.rx_lvl = q_r.rx_sync[2];
    end
    // miso arrives after the setup cycles of this path
    if (q_r.mi_sync[2] == q_r.mi_sync[1])
    begin
      q_nxt.mi_lvl = q_r.mi_sync[2];
    end
    // a write fills the transmit buffer
    if (I_TX_WRITE)
    begin
      q_nxt.tx_buf = I_CFG.msb_first ? bit_swap(I_TX_DATA) : I_TX_DATA;
      q_nxt.tx_empty = 1'b0;
    end
    if (I_RX_READ)
    begin
      q_nxt.rx_flag = 1'b0;
      q_nxt.rts = 1'b0;
    end
    // flag clears come first so that a same-cycle set wins
    if (I_ERR_CLEAR)
    begin
      q_nxt.err_flag = 1'b0;
    end
    if (I_TMR_CLEAR)
    begin
      q_nxt.tmr_flag = 1'b0;
    end
    // low counter runs whenever the timer is enabled
    if (q_r.st != FSE_IDLE)
    begin
      q_nxt.lo = expire ? half : q_r.lo - 8'h01;
    end
    case (q_r.st)
      FSE_IDLE:
      begin
        if (I_CFG.spi_mode)
        begin
          // trigger is the inverted transmit status flag
          if (!q_r.tx_empty)
          begin
            q_nxt.st = FSE_RUN;
            q_nxt.lo = half;
            q_nxt.cnt = I_CFG.timer_compare_value[15:8];
            q_nxt.rx_sh = `FSE_WORD_RST;
            q_nxt.tx_empty = I_TX_WRITE ? 1'b0 : 1'b1;
            // select asserted while the clock timer runs
            q_nxt.ss_n = 1'b0;
            q_nxt.tclk = 1'b0;
            // phase 0 puts the first bit out at load
            if (!I_CFG.cpha)
            begin
              q_nxt.mosi = q_r.tx_buf[0];
              q_nxt.tx_sh = {1'b0, q_r.tx_buf[31:1]};
            end
            else
            begin
              q_nxt.tx_sh = q_r.tx_buf;
            end
          end
        end
        // request-to-send flag gates the start trigger
        // no start detection while request-to-send is up
        else if (start_seen && !(I_CFG.rts_en && q_r.rts))
        begin
          // enable on the start edge, output starts high
          q_nxt.st = FSE_RUN;
          q_nxt.lo = half;
          q_nxt.tclk = 1'b1;
          q_nxt.first = 1'b1;
          q_nxt.rx_sh = `FSE_WORD_RST;
          // data bits from the upper byte: ((n * 2) - 1) / 2 + 1
          q_nxt.cnt = {1'b0, I_CFG.timer_compare_value[15:9]} + 8'h01;
          // held until a read, never compares
          if (I_CFG.rts_en)
          begin
            q_nxt.rts = 1'b1;
          end
        end
      end
      FSE_RUN:
      begin
        if (!I_CFG.spi_mode)
        begin
          // with request-to-send enabled, an input edge realigns the next sample point
          if (I_CFG.rts_en && rx_edge && !expire)
          begin
            q_nxt.lo = half;
            q_nxt.tclk = 1'b1;
          end
          else if (expire)
          begin
            q_nxt.tclk = ~q_r.tclk;
            // sample on the falling edge of the shift clock
            if (q_r.tclk)
            begin
              if (q_r.first)
              begin
                q_nxt.first = 1'b0;
                // start bit must read as 0
                if ((I_CFG.shifter_start_bit_cfg == `FSE_START_CHECK) && rx_bit)
                begin
                  q_nxt.err_flag = 1'b1;
                end
              end
              else if (q_r.cnt != `FSE_BYTE_RST)
              begin
                q_nxt.rx_sh = rx_word;
                q_nxt.cnt = q_r.cnt - 8'h01;
              end
              else
              begin
                // stop bit checked, word stored, timer disabled
                q_nxt.st = FSE_IDLE;
                q_nxt.tmr_flag = 1'b1;
                if ((I_CFG.shifter_stop_bit_cfg == `FSE_STOP_CHECK) && !rx_bit)
                begin
                  // a break frame reads back as zero
                  q_nxt.err_flag = 1'b1;
                  q_nxt.rx_buf = `FSE_WORD_RST;
                end
                else
                begin
                  // present the byte- or bit-swapped view
                  q_nxt.rx_buf = I_CFG.msb_first ? bit_swap(q_r.rx_sh) : byte_swap(q_r.rx_sh);
                end
                // unread word overwritten is an error
                if (q_r.rx_flag && !I_RX_READ)
                begin
                  q_nxt.err_flag = 1'b1;
                end
                q_nxt.rx_flag = 1'b1;
              end
            end
          end
        end
        else if (expire)
        begin
          q_nxt.tclk = ~q_r.tclk;
          q_nxt.cnt = q_r.cnt - 8'h01;
          // rising edge of the shift clock
          if (!q_r.tclk)
          begin
            if (!I_CFG.cpha)
            begin
              // phase 0 samples miso on the rise
              q_nxt.rx_sh = rx_word;
            end
            else
            begin
              // phase 1 loads data on the first shift
              q_nxt.mosi = q_r.tx_sh[0];
              q_nxt.tx_sh = {1'b0, q_r.tx_sh[31:1]};
            end
          end
          else
          begin
            if (!I_CFG.cpha)
            begin
              // phase 0 drives the next bit on the fall
              q_nxt.mosi = q_r.tx_sh[0];
              q_nxt.tx_sh = {1'b0, q_r.tx_sh[31:1]};
            end
            else
            begin
              // phase 1 samples on the fall
              q_nxt.rx_sh = rx_word;
            end
          end
          // compare after upper byte plus one edges
          if (q_r.cnt == `FSE_BYTE_RST)
          begin
            q_nxt.tclk = 1'b0;
            q_nxt.tmr_flag = 1'b1;
            q_nxt.rx_buf = I_CFG.msb_first ? bit_swap(q_nxt.rx_sh) : byte_swap(q_nxt.rx_sh);
            if (q_r.rx_flag && !I_RX_READ)
            begin
              q_nxt.err_flag = 1'b1;
            end
            q_nxt.rx_flag = 1'b1;
            q_nxt.st = FSE_STOP;
            // phase 1 keeps select low while data waits
            if (I_CFG.cpha && !q_r.tx_empty)
            begin
              q_nxt.st = FSE_RUN;
              q_nxt.cnt = I_CFG.timer_compare_value[15:8];
              q_nxt.tx_sh = q_r.tx_buf;
              q_nxt.tx_empty = I_TX_WRITE ? 1'b0 : 1'b1;
            end
          end
        end
      end
      FSE_STOP:
      begin
        // stop half period spaces consecutive words
        if (expire)
        begin
          q_nxt.st = FSE_IDLE;
          q_nxt.ss_n = 1'b1;
        end
      end
      default:
      begin
        q_nxt.st = FSE_IDLE;
      end
    endcase
    // clock pin idles low, optional inversion
    q_nxt.sck = (q_nxt.st == FSE_RUN) && I_CFG.spi_mode ? q_nxt.tclk : 1'b0;
    q_nxt.sck = q_nxt.sck ^ (I_CFG.spi_mode && I_CFG.timer_pin_invert);
  end

  // state register, synchronous reset
  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
    begin
      q_r <= '{st: FSE_IDLE, rx_sync: 3'h7, mi_sync: 3'h0, rx_lvl: 1'b1, mi_lvl: 1'b0,
               tclk: 1'b0, first: 1'b0, lo: `FSE_BYTE_RST, cnt: `FSE_BYTE_RST,
               rx_sh: `FSE_WORD_RST, tx_sh: `FSE_WORD_RST, tx_buf: `FSE_WORD_RST,
               tx_empty: 1'b1, rx_buf: `FSE_WORD_RST, rx_flag: 1'b0, err_flag: 1'b0,
               tmr_flag: 1'b0, rts: 1'b0, mosi: 1'b0, sck: 1'b0, ss_n: 1'b1};
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  // outputs straight from the state register
  // flags raise events; ready doubles as dma request
  assign O_RX_DATA = q_r.rx_buf;
  assign O_RX_READY = q_r.rx_flag;
  assign O_RX_ERROR = q_r.err_flag;
  assign O_TIMER_DONE = q_r.tmr_flag;
  assign O_TX_EMPTY = q_r.tx_empty;
  // request-to-send pin, active high while blocking
  assign O_RTS = q_r.rts;
  assign O_MOSI = q_r.mosi;
  assign O_SCK = q_r.sck;
  assign O_SS_N = q_r.ss_n;

endmodule // fse_engine
`default_nettype wire

/* File: testbench/fse_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// port checker for the serial engine, sees only top ports
module fse_assertions
  import fse_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire fse_cfg_t I_CFG,
  input wire logic I_TX_WRITE,
  input wire logic I_RX_READ,
  input wire logic I_ERR_CLEAR,
  input wire logic I_TMR_CLEAR,
  input wire logic O_RX_READY,
  input wire logic O_RX_ERROR,
  input wire logic O_TIMER_DONE,
  input wire logic O_TX_EMPTY,
  input wire logic O_RTS,
  input wire logic O_MOSI,
  input wire logic O_SCK,
  input wire logic O_SS_N
);
  // one clock domain, reset masks every check
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  a_write_fills:
  assert property (I_TX_WRITE |=> !O_TX_EMPTY) else $error("buffer not filled");
  a_empty_holds:
  assert property (O_TX_EMPTY && !I_TX_WRITE |=> O_TX_EMPTY) else $error("empty lost");
  a_ready_holds:
  assert property (O_RX_READY && !I_RX_READ |=> O_RX_READY) else $error("ready lost");
  a_ready_drop:
  assert property ($fell(O_RX_READY) |-> $past(I_RX_READ)) else $error("ready fell alone");
  a_err_holds:
  assert property (O_RX_ERROR && !I_ERR_CLEAR |=> O_RX_ERROR) else $error("error lost");
  a_done_holds:
  assert property (O_TIMER_DONE && !I_TMR_CLEAR |=> O_TIMER_DONE) else $error("done lost");
  a_rts_read:
  assert property (O_RTS && I_RX_READ |=> !O_RTS) else $error("rts kept after read");
  a_rts_holds:
  assert property (O_RTS && !I_RX_READ |=> O_RTS) else $error("rts dropped");
  a_rts_cause:
  assert property ($rose(O_RTS) |-> I_CFG.rts_en) else $error("rts without enable");
  a_sck_idle:
  assert property (O_SS_N && I_CFG.spi_mode && !I_CFG.timer_pin_invert |-> !O_SCK)
    else $error("clock not idle low");
  a_sck_slow:
  assert property (I_CFG.spi_mode && $changed(O_SCK) |=> $stable(O_SCK) [*3])
    else $error("clock too fast");
  a_mosi_rise:
  assert property (I_CFG.spi_mode && !I_CFG.cpha && !O_SS_N && $rose(O_SCK)
    |-> $stable(O_MOSI)) else $error("data moved on rise");
endmodule // fse_assertions
`default_nettype wire

/* File: testbench/fse_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
// far end: a serial transmitter, lsb or msb first, and a spi slave, lsb first
module fse_far_end
(
  input wire logic i_clk,
  input wire logic i_cpha,
  input wire logic i_sck,
  input wire logic i_ss_n,
  input wire logic i_mosi,
  output logic o_rxd,
  output logic o_miso
);
  logic [31:0] slv_word = 32'h0; // word sent to the master
  logic [31:0] got_word = 32'h0; // word taken from the master
  int bit_n = 0; // bits moved in this transfer
  initial o_rxd = 1'b1;
  initial o_miso = 1'b0;
  task send(input logic [7:0] d, input logic msb, input logic stop, input int h);
    // the line moves 1 ns after an edge, never in the edge's own time step
    o_rxd = 1'b0;
    repeat (2 * h) @(posedge i_clk);
    #1;
    for (int i = 0; i < 8; i++)
    begin
      o_rxd = msb ? d[7 - i] : d[i];
      repeat (2 * h) @(posedge i_clk);
      #1;
    end
    o_rxd = stop;
    repeat (2 * h) @(posedge i_clk);
    #1;
    o_rxd = 1'b1;
    repeat (2 * h) @(posedge i_clk);
    #1;
  endtask
  // phase 0 needs the first bit ready before the first rise
  always @(negedge i_ss_n)
  begin
    bit_n = 0;
    if (!i_cpha)
      o_miso <= slv_word[0];
  end
  // released line has no pull: show the inverse, not a stale value
  always @(posedge i_ss_n)
    o_miso <= ~o_miso;
  // sample on one edge, drive on the other
  always @(i_sck)
    if (!i_ss_n && (i_sck ^ i_cpha))
    begin
      got_word[bit_n[4:0]] = i_mosi;
      bit_n++;
    end
    else if (!i_ss_n)
      o_miso <= (bit_n < 32) ? slv_word[bit_n[4:0]] : ~o_miso;
endmodule // fse_far_end
`default_nettype wire

/* File: testbench/test_fse_engine.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fse_consts.svh"
// bench: uart receive, rts, errors, spi master in both phases
module test_fse_engine
  import fse_pkg::*;
;
  localparam int HALF = (`FSE_UART_CMP_DFLT & 16'hff) + 1; // half bit in cycles
  logic clk = 1'b0;
  logic rst = 1'b1;
  fse_cfg_t cfg;
  logic rxd, miso, wr, rd, eclr, tclr;
  logic [31:0] txd, rxq;
  logic rdy, err, done, emp, rts, mosi, sck, ss_n;
  logic [31:0] swp; // expected received view of the slave word
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  fse_engine i_dut (.I_MCLK(clk), .I_RST(rst), .I_CFG(cfg), .I_RXD(rxd), .I_MISO(miso),
    .I_TX_DATA(txd), .I_TX_WRITE(wr), .I_RX_READ(rd), .I_ERR_CLEAR(eclr),
    .I_TMR_CLEAR(tclr), .O_RX_DATA(rxq), .O_RX_READY(rdy), .O_RX_ERROR(err),
    .O_TIMER_DONE(done), .O_TX_EMPTY(emp), .O_RTS(rts), .O_MOSI(mosi), .O_SCK(sck),
    .O_SS_N(ss_n));
  fse_far_end i_far (.i_clk(clk), .i_cpha(cfg.cpha), .i_sck(sck), .i_ss_n(ss_n),
    .i_mosi(mosi), .o_rxd(rxd), .o_miso(miso));
  // 200 MHz clock
  initial
    forever #2.5 clk = ~clk;
  // hang guard, a full run is about 900 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_fail++;
      print_verdict;
    end
  end
  // inputs move 1 ns after the edge
  task tick;
    @(posedge clk);
    #1;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // one-cycle strobe
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick;
    s = 1'b0;
    tick;
  endtask
  // bounded wait for a flag
  task automatic wait_for(ref logic s);
    for (int i = 0; i < 2000 && s !== 1'b1; i++)
      tick;
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    cfg = '0;
    cfg.timer_compare_value = `FSE_UART_CMP_DFLT;
    cfg.shifter_stop_bit_cfg = `FSE_STOP_CHECK;
    cfg.shifter_start_bit_cfg = `FSE_START_CHECK;
    {wr, rd, eclr, tclr} = 4'h0;
    txd = 32'h0;
    repeat (5) tick;
    check({emp, ss_n, rts, rdy}, 32'hc);
    rst = 1'b0;
    repeat (8) tick;
    // lsb then msb first frames, low byte of the view
    for (int m = 0; m < 2; m++)
    begin
      cfg.msb_first = m[0];
      i_far.send(8'h4d, m[0], 1'b1, HALF);
      check({done, rdy, err}, 32'h6);
      check({24'h0, rxq[7:0]}, 32'h4d);
      pulse(rd);
      pulse(tclr);
      check({rdy, done}, 32'h0);
    end
    // break frame then overrun
    i_far.send(8'h00, 1'b0, 1'b0, HALF);
    check({err, 23'h0, rxq[7:0]}, 32'h8000_0000);
    pulse(eclr);
    pulse(rd);
    i_far.send(8'h11, 1'b0, 1'b1, HALF);
    i_far.send(8'h22, 1'b0, 1'b1, HALF);
    check({31'h0, err}, 32'h1);
    pulse(eclr);
    pulse(rd);
    // request-to-send blocks a second frame until the read
    cfg.rts_en = 1'b1;
    i_far.send(8'h3c, 1'b0, 1'b1, HALF);
    check({rts, rdy}, 32'h3);
    i_far.send(8'h55, 1'b0, 1'b1, HALF);
    check({err, 23'h0, rxq[7:0]}, 32'h3c);
    pulse(rd);
    check({31'h0, rts}, 32'h0);
    pulse(tclr);
    // spi master, phase 0 then phase 1
    cfg = '0;
    cfg.spi_mode = 1'b1;
    cfg.timer_compare_value = `FSE_SPI_CMP_DFLT;
    tick;
    for (int p = 0; p < 2; p++)
    begin
      cfg.cpha = p[0];
      i_far.slv_word = 32'hc35a_1e87 ^ p;
      txd = 32'h9b3e_5a61 + p;
      pulse(wr);
      wait_for(done);
      check(i_far.got_word, txd);
      // lsb-first words come back byte-swapped; the expected slave word is swapped to match
      swp = {i_far.slv_word[7:0], i_far.slv_word[15:8], i_far.slv_word[23:16],
        i_far.slv_word[31:24]};
      check(rxq, swp);
      wait_for(ss_n);
      check({30'h0, ss_n, emp}, 32'h3);
      pulse(rd);
      pulse(tclr);
    end
    print_verdict;
  end
endmodule // test_fse_engine
bind fse_engine fse_assertions u_chk (.I_MCLK, .I_RST, .I_CFG, .I_TX_WRITE, .I_RX_READ,
  .I_ERR_CLEAR, .I_TMR_CLEAR, .O_RX_READY, .O_RX_ERROR, .O_TIMER_DONE, .O_TX_EMPTY,
  .O_RTS, .O_MOSI, .O_SCK, .O_SS_N);
`default_nettype wire
